// *** rtl/pcr_pkg.sv ***
// Purpose: shared constants and types for the express capability register bank
// Assumes: byte addresses on the register port, one 32-bit word per register
// Notes: field positions are bit numbers inside the two capability words
`default_nettype none
package pcr_pkg;
   localparam int PCR_ADDR_W = 12;
   localparam int PCR_DATA_W = 32;
   localparam logic [11:0] PCR_HDR_OFFSET = 12'h040;
   localparam logic [11:0] PCR_DCAP_OFFSET = 12'h044;

   // capability header word
   localparam int PCR_CAPABILITY_IDENTIFIER_LSB = 0;
   localparam int PCR_NEXT_LSB = 8;
   localparam int PCR_VER_LSB = 16;
   localparam int PCR_TYPE_LSB = 20;
   localparam int PCR_SLOT_BIT = 24;
   localparam int PCR_IMN_LSB = 25;
   localparam int PCR_TCS_BIT = 30;
   localparam int PCR_HDR_RSVD_BIT = 31;

   // device capabilities word
   localparam int PCR_MPS_LSB = 0;
   localparam int PCR_PFS_LSB = 3;
   localparam int PCR_EXTENDED_TAG_SUPPORTED_BIT = 5;
   localparam int PCR_L0S_LSB = 6;
   localparam int PCR_L1_LSB = 9;
   localparam int PCR_ABP_BIT = 12;
   localparam int PCR_AIP_BIT = 13;
   localparam int PCR_PIP_BIT = 14;
   localparam int PCR_RBER_BIT = 15;
   localparam int PCR_DCAP_RSVD_LSB = 16;
   localparam int PCR_SPLV_LSB = 18;
   localparam int PCR_SPLS_LSB = 26;
   localparam int PCR_DCAP_RSVD2_LSB = 28;

   localparam logic [7:0] PCR_CAPABILITY_IDENTIFIER_VALUE = 8'h10;
   localparam logic [7:0] PCR_NEXT_RESET = 8'hC0;
   localparam logic [3:0] PCR_VER_RESET = 4'h1;
   localparam logic [3:0] PCR_TYPE_UPSTREAM = 4'h5;
   localparam logic [3:0] PCR_TYPE_DOWNSTREAM = 4'h6;
   localparam logic PCR_SLOT_RESET = 1'b0;
   localparam logic [4:0] PCR_IMN_VALUE = 5'h00;
   localparam logic PCR_TCS_RESET = 1'b1;
   localparam logic [2:0] PCR_MPS_RESET = 3'h4;
   localparam logic [1:0] PCR_PFS_VALUE = 2'h0;
   localparam logic PCR_EXTENDED_TAG_SUPPORTED_RESET = 1'b1;
   localparam logic [2:0] PCR_LAT_VALUE = 3'h0;
   localparam logic PCR_PRESENT_VALUE = 1'b0;
   localparam logic PCR_RBER_VALUE = 1'b1;
   localparam logic [7:0] PCR_SPLV_RESET = 8'h00;
   localparam logic [1:0] PCR_SPLS_RESET = 2'h0;
   localparam logic [31:0] PCR_ZERO_WORD = 32'h0000_0000;

   // milliwatt factor for each scale code
   localparam int PCR_MW_W = 18;
   localparam logic [1:0] PCR_SCALE_X1 = 2'h0;
   localparam logic [1:0] PCR_SCALE_X0P1 = 2'h1;
   localparam logic [1:0] PCR_SCALE_X0P01 = 2'h2;
   localparam logic [17:0] PCR_MW_X1 = 18'h0_03E8;
   localparam logic [17:0] PCR_MW_X0P1 = 18'h0_0064;
   localparam logic [17:0] PCR_MW_X0P01 = 18'h0_000A;
   localparam logic [17:0] PCR_MW_X0P001 = 18'h0_0001;

   typedef struct packed {
      logic [7:0] following_structure_pointer;
      logic [3:0] structure_version;
      logic slot_implemented;
      logic traffic_class_routing_supported;
      logic [2:0] max_payload_supported;
      logic extended_tag_supported;
   } pcr_lockable_type;

   localparam pcr_lockable_type PCR_LOCKABLE_RESET = '{
      following_structure_pointer: PCR_NEXT_RESET,
      structure_version: PCR_VER_RESET,
      slot_implemented: PCR_SLOT_RESET,
      traffic_class_routing_supported: PCR_TCS_RESET,
      max_payload_supported: PCR_MPS_RESET,
      extended_tag_supported: PCR_EXTENDED_TAG_SUPPORTED_RESET
   };
endpackage
`default_nettype wire

// *** rtl/pcr_field_if.sv ***
// Purpose: write path between the decoder and the lockable field store
// Assumes: one clock; strobes are single-cycle
// Notes: the store answers with its current field values
`default_nettype none
interface pcr_field_if;
   logic hdr_wr;
   logic dcap_wr;
   logic locked;
   logic [31:0] wdata;
   pcr_pkg::pcr_lockable_type fields;
   modport ctrl (output hdr_wr, output dcap_wr, output locked, output wdata, input fields);
   modport store (input hdr_wr, input dcap_wr, input locked, input wdata, output fields);
endinterface
`default_nettype wire

// *** rtl/pcr_lockable_store.sv ***
// Purpose: holds the software-writable capability fields
// Assumes: write strobes come from the address decoder of the top
// Notes: a write while locked is dropped silently
`default_nettype none
module pcr_lockable_store (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   pcr_field_if.store fif
);
   import pcr_pkg::*;

   pcr_lockable_type fields_q;
   pcr_lockable_type fields_d;

   always_comb begin
      fields_d = fields_q;
      if (fif.hdr_wr && !fif.locked) begin
         fields_d.following_structure_pointer = fif.wdata[PCR_NEXT_LSB +: 8]; // see R2
         fields_d.structure_version = fif.wdata[PCR_VER_LSB +: 4]; // see R3
         fields_d.slot_implemented = fif.wdata[PCR_SLOT_BIT];
         fields_d.traffic_class_routing_supported = fif.wdata[PCR_TCS_BIT]; // see R7
      end
      if (fif.dcap_wr && !fif.locked) begin
         fields_d.max_payload_supported = fif.wdata[PCR_MPS_LSB +: 3]; // see R8
         fields_d.extended_tag_supported = fif.wdata[PCR_EXTENDED_TAG_SUPPORTED_BIT]; // see R10
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fields_q <= PCR_LOCKABLE_RESET;
      end else begin
         fields_q <= fields_d;
      end
   end

   assign fif.fields = fields_q;
endmodule
`default_nettype wire

// *** rtl/pcr_power_capture.sv ***
// Purpose: captures the slot power limit carried by a set-power-limit message
// Assumes: the message decoder gives a one-cycle valid with value and scale
// Notes: only the upstream port captures; a downstream port holds zero
`default_nettype none
module pcr_power_capture (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic upstream_i,
   input wire logic msg_valid_i,
   input wire logic [7:0] msg_value_i,
   input wire logic [1:0] msg_scale_i,
   output logic [7:0] limit_value_o,
   output logic [1:0] limit_scale_o
);
   import pcr_pkg::*;

   logic [7:0] value_q;
   logic [1:0] scale_q;
   wire take_w = msg_valid_i && upstream_i; // see R15

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         value_q <= PCR_SPLV_RESET;
         scale_q <= PCR_SPLS_RESET;
      end else if (take_w) begin
         value_q <= msg_value_i; // see R14
         scale_q <= msg_scale_i; // see R16
      end
   end

   // masked as well so a downstream port can never show a stale value
   assign limit_value_o = upstream_i ? value_q : PCR_SPLV_RESET; // see R15
   assign limit_scale_o = upstream_i ? scale_q : PCR_SPLS_RESET; // see R15
endmodule
`default_nettype wire

// *** rtl/pcr_regs.sv ***
// Purpose: express capability header and device capabilities words of a switch port
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: the locking mechanism lives outside; it arrives as a level input
//
// Function
// R1: bits 7:0 of the header always read 0x10, the express capability id.
// R2: header bits 15:8 hold the following structure pointer, reset 0xC0, writable while unlocked.
// R3: header bits 19:16 hold the structure version, reset 0x1, writable while unlocked.
// R4: header bits 23:20 are read-only port type, 0x5 upstream and 0x6 downstream.
// R5: software sets slot implemented (bit 24, reset 0) only for a slot and keeps it 0 upstream.
// R6: header bits 29:25, the interrupt message number, always read zero.
// R7: header bit 30, traffic class routing supported, resets to 1 and is writable while unlocked.
// R8: device bits 2:0 advertise max payload, reset 0x4 for 2048 bytes, writable while unlocked.
// R9: device bits 4:3, phantom functions supported, are fixed at zero.
// R10: device bit 5, extended tag supported, resets to 1 and is writable while unlocked.
// R11: device bits 8:6 and 11:9, endpoint latencies, are fixed at zero.
// R12: device bits 12 to 14, the indicator and button presence flags, read zero.
// R13: device bit 15 reads one for role based error reporting.
// R14: device bits 25:18 hold the captured power limit value, watts being value times scale.
// R15: the upstream port loads value and scale from each power limit message; downstream reads 0.
// R16: device bits 27:26 hold the captured scale, codes 0..3 meaning 1.0, 0.1, 0.01, 0.001.
// R17: reserved bits read zero and writes to them or to read-only fields do nothing.
//
// Local design decision: the strobed register port.
`default_nettype none
module pcr_regs (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [pcr_pkg::PCR_ADDR_W-1:0] reg_addr_i,
   input wire logic [pcr_pkg::PCR_DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [pcr_pkg::PCR_DATA_W-1:0] reg_rdata_o,
   // port configuration
   input wire logic port_upstream_i,
   input wire logic fields_locked_i,
   // received power limit message
   input wire logic spl_msg_valid_i,
   input wire logic [7:0] spl_msg_value_i,
   input wire logic [1:0] spl_msg_scale_i,
   // advertised state for the rest of the port
   output logic port_upstream_o,
   output logic slot_implemented_o,
   output logic [2:0] max_payload_supported_o,
   output logic extended_tag_supported_o,
   output logic traffic_class_routing_o,
   output logic [7:0] captured_power_limit_value_o,
   output logic [1:0] captured_power_limit_scale_o,
   output logic [pcr_pkg::PCR_MW_W-1:0] slot_power_mw_o
);
   import pcr_pkg::*;

   // ---------------------------------------------------------------
   // port role strap, taken once at the first edge after reset
   // ---------------------------------------------------------------
   logic strap_taken_q;
   logic upstream_q;

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         strap_taken_q <= 1'b0;
         upstream_q <= 1'b0;
      end else if (!strap_taken_q) begin
         strap_taken_q <= 1'b1;
         upstream_q <= port_upstream_i;
      end
   end

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire hit_hdr_w = (reg_addr_i == PCR_HDR_OFFSET);
   wire hit_dcap_w = (reg_addr_i == PCR_DCAP_OFFSET);
   wire wr_hdr_w = reg_wr_i && hit_hdr_w;
   wire wr_dcap_w = reg_wr_i && hit_dcap_w;

   // ---------------------------------------------------------------
   // lockable field store
   // ---------------------------------------------------------------
   pcr_field_if fif ();

   assign fif.hdr_wr = wr_hdr_w;
   assign fif.dcap_wr = wr_dcap_w;
   assign fif.locked = fields_locked_i;
   assign fif.wdata = reg_wdata_i;

   pcr_lockable_store u_store (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .fif(fif)
   );

   pcr_lockable_type fields_w;
   assign fields_w = fif.fields;

   // ---------------------------------------------------------------
   // power limit capture
   // ---------------------------------------------------------------
   wire [7:0] spl_value_w;
   wire [1:0] spl_scale_w;

   pcr_power_capture u_power (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .upstream_i(upstream_q),
      .msg_valid_i(spl_msg_valid_i),
      .msg_value_i(spl_msg_value_i),
      .msg_scale_i(spl_msg_scale_i),
      .limit_value_o(spl_value_w),
      .limit_scale_o(spl_scale_w)
   );

   // ceiling in milliwatts keeps the product integer for every scale code
   wire [PCR_MW_W-1:0] mw_factor_w =
      (spl_scale_w == PCR_SCALE_X1)    ? PCR_MW_X1 :
      (spl_scale_w == PCR_SCALE_X0P1)  ? PCR_MW_X0P1 :
      (spl_scale_w == PCR_SCALE_X0P01) ? PCR_MW_X0P01 :
                                         PCR_MW_X0P001; // see R16
   wire [PCR_MW_W-1:0] power_mw_w = PCR_MW_W'(PCR_MW_W'(spl_value_w) * mw_factor_w); // see R14

   // ---------------------------------------------------------------
   // header word
   // ---------------------------------------------------------------
   wire [3:0] port_type_w = upstream_q ? PCR_TYPE_UPSTREAM : PCR_TYPE_DOWNSTREAM; // see R4
   logic [31:0] hdr_word_w;

   always_comb begin
      hdr_word_w = PCR_ZERO_WORD; // see R17
      hdr_word_w[PCR_CAPABILITY_IDENTIFIER_LSB +: 8] = PCR_CAPABILITY_IDENTIFIER_VALUE; // see R1
      hdr_word_w[PCR_NEXT_LSB +: 8] = fields_w.following_structure_pointer; // see R2
      hdr_word_w[PCR_VER_LSB +: 4] = fields_w.structure_version; // see R3
      hdr_word_w[PCR_TYPE_LSB +: 4] = port_type_w; // see R4
      // stored as written; keeping it clear upstream is software's part, see R5
      hdr_word_w[PCR_SLOT_BIT] = fields_w.slot_implemented;
      hdr_word_w[PCR_IMN_LSB +: 5] = PCR_IMN_VALUE; // see R6
      hdr_word_w[PCR_TCS_BIT] = fields_w.traffic_class_routing_supported; // see R7
      hdr_word_w[PCR_HDR_RSVD_BIT] = 1'b0; // see R17
   end

   // ---------------------------------------------------------------
   // device capabilities word
   // ---------------------------------------------------------------
   logic [31:0] dcap_word_w;

   always_comb begin
      dcap_word_w = PCR_ZERO_WORD; // see R17
      dcap_word_w[PCR_MPS_LSB +: 3] = fields_w.max_payload_supported; // see R8
      dcap_word_w[PCR_PFS_LSB +: 2] = PCR_PFS_VALUE; // see R9
      dcap_word_w[PCR_EXTENDED_TAG_SUPPORTED_BIT] = fields_w.extended_tag_supported; // see R10
      dcap_word_w[PCR_L0S_LSB +: 3] = PCR_LAT_VALUE; // see R11
      dcap_word_w[PCR_L1_LSB +: 3] = PCR_LAT_VALUE; // see R11
      dcap_word_w[PCR_ABP_BIT] = PCR_PRESENT_VALUE; // see R12
      dcap_word_w[PCR_AIP_BIT] = PCR_PRESENT_VALUE; // see R12
      dcap_word_w[PCR_PIP_BIT] = PCR_PRESENT_VALUE; // see R12
      dcap_word_w[PCR_RBER_BIT] = PCR_RBER_VALUE; // see R13
      dcap_word_w[PCR_DCAP_RSVD_LSB +: 2] = 2'h0; // see R17
      dcap_word_w[PCR_SPLV_LSB +: 8] = spl_value_w; // see R14
      dcap_word_w[PCR_SPLS_LSB +: 2] = spl_scale_w; // see R16
      dcap_word_w[PCR_DCAP_RSVD2_LSB +: 4] = 4'h0; // see R17
   end

   // ---------------------------------------------------------------
   // read selection; unmapped addresses and idle cycles read zero
   // ---------------------------------------------------------------
   wire [31:0] rd_sel_w =
      (reg_rd_i && hit_hdr_w)  ? hdr_word_w :
      (reg_rd_i && hit_dcap_w) ? dcap_word_w :
                                 PCR_ZERO_WORD;

   logic [31:0] rdata_q;

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= PCR_ZERO_WORD;
      end else begin
         rdata_q <= rd_sel_w;
      end
   end

   // ---------------------------------------------------------------
   // registered copies of the advertised state
   // ---------------------------------------------------------------
   logic slot_q;
   logic [2:0] mps_q;
   logic extended_tag_supported_q;
   logic tcs_q;
   logic [7:0] splv_q;
   logic [1:0] spls_q;
   logic [PCR_MW_W-1:0] mw_q;

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         slot_q <= PCR_SLOT_RESET;
         mps_q <= PCR_MPS_RESET;
         extended_tag_supported_q <= PCR_EXTENDED_TAG_SUPPORTED_RESET;
         tcs_q <= PCR_TCS_RESET;
         splv_q <= PCR_SPLV_RESET;
         spls_q <= PCR_SPLS_RESET;
         mw_q <= '0;
      end else begin
         slot_q <= fields_w.slot_implemented;
         mps_q <= fields_w.max_payload_supported;
         extended_tag_supported_q <= fields_w.extended_tag_supported;
         tcs_q <= fields_w.traffic_class_routing_supported;
         splv_q <= spl_value_w;
         spls_q <= spl_scale_w;
         mw_q <= power_mw_w;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign port_upstream_o = upstream_q;
   assign slot_implemented_o = slot_q;
   assign max_payload_supported_o = mps_q;
   assign extended_tag_supported_o = extended_tag_supported_q;
   assign traffic_class_routing_o = tcs_q;
   assign captured_power_limit_value_o = splv_q;
   assign captured_power_limit_scale_o = spls_q;
   assign slot_power_mw_o = mw_q;
endmodule
`default_nettype wire

// *** verification/pcr_regs_properties.sv ***
// Purpose: port-level properties of the express capability register bank
// Assumes: one clock, reset asynchronous and active high
// Notes: derived outputs lag the field store by one cycle
`default_nettype none
module pcr_regs_properties (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [pcr_pkg::PCR_ADDR_W-1:0] reg_addr_i,
   input wire logic [pcr_pkg::PCR_DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [pcr_pkg::PCR_DATA_W-1:0] reg_rdata_o,
   input wire logic port_upstream_i,
   input wire logic fields_locked_i,
   input wire logic spl_msg_valid_i,
   input wire logic [7:0] spl_msg_value_i,
   input wire logic [1:0] spl_msg_scale_i,
   input wire logic port_upstream_o,
   input wire logic slot_implemented_o,
   input wire logic [2:0] max_payload_supported_o,
   input wire logic extended_tag_supported_o,
   input wire logic traffic_class_routing_o,
   input wire logic [7:0] captured_power_limit_value_o,
   input wire logic [1:0] captured_power_limit_scale_o,
   input wire logic [pcr_pkg::PCR_MW_W-1:0] slot_power_mw_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import pcr_pkg::*;
   logic hdr_rd;
   logic dcap_rd;
   logic [2:0] wd_mps;
   assign hdr_rd = reg_rd_i && reg_addr_i == PCR_HDR_OFFSET;
   assign dcap_rd = reg_rd_i && reg_addr_i == PCR_DCAP_OFFSET;
   assign wd_mps = reg_wdata_i[2:0];

   function automatic logic [17:0] mw_of(input logic [7:0] v, input logic [1:0] s);
      logic [17:0] f;
      f = (s == 2'h0) ? PCR_MW_X1 : (s == 2'h1) ? PCR_MW_X0P1 :
          (s == 2'h2) ? PCR_MW_X0P01 : PCR_MW_X0P001;
      return {10'h000, v} * f;
   endfunction

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 32'h0000_0000; endproperty
   property p_hdr_fixed;
      hdr_rd |=> reg_rdata_o[7:0] == 8'h10 && reg_rdata_o[29:25] == 5'h00 && !reg_rdata_o[31];
   endproperty
   property p_hdr_type;
      hdr_rd |=> reg_rdata_o[23:20] == (port_upstream_o ? 4'h5 : 4'h6);
   endproperty
   property p_hdr_live;
      hdr_rd |=> reg_rdata_o[30] == traffic_class_routing_o
         && reg_rdata_o[24] == slot_implemented_o;
   endproperty
   property p_dcap_fixed;
      dcap_rd |=> reg_rdata_o[17:6] == 12'h200 && reg_rdata_o[4:3] == 2'h0
         && reg_rdata_o[31:28] == 4'h0;
   endproperty
   property p_dcap_live;
      dcap_rd |=> reg_rdata_o[2:0] == max_payload_supported_o
         && reg_rdata_o[5] == extended_tag_supported_o
         && reg_rdata_o[25:18] == captured_power_limit_value_o
         && reg_rdata_o[27:26] == captured_power_limit_scale_o;
   endproperty
   property p_capture;
      spl_msg_valid_i && port_upstream_o |-> ##2
         captured_power_limit_value_o == $past(spl_msg_value_i, 2)
         && captured_power_limit_scale_o == $past(spl_msg_scale_i, 2);
   endproperty
   property p_down_zero;
      !port_upstream_o |-> captured_power_limit_value_o == 8'h00
         && captured_power_limit_scale_o == 2'h0;
   endproperty
   property p_mw;
      slot_power_mw_o == mw_of(captured_power_limit_value_o, captured_power_limit_scale_o);
   endproperty
   property p_lock;
      reg_wr_i && fields_locked_i |-> ##2 $stable(max_payload_supported_o)
         && $stable(extended_tag_supported_o) && $stable(traffic_class_routing_o)
         && $stable(slot_implemented_o);
   endproperty
   property p_wr_dcap;
      reg_wr_i && !fields_locked_i && reg_addr_i == PCR_DCAP_OFFSET |-> ##2
         max_payload_supported_o == $past(wd_mps, 2)
         && extended_tag_supported_o == $past(reg_wdata_i[5], 2);
   endproperty

   a_rd_idle:
      assert property (p_rd_idle) else $error("read data not zero outside a read");
   a_hdr_fixed:
      assert property (p_hdr_fixed) else $error("header fixed fields wrong");
   a_hdr_type:
      assert property (p_hdr_type) else $error("port type wrong");
   a_hdr_live:
      assert property (p_hdr_live) else $error("header lockable bits disagree");
   a_dcap_fixed:
      assert property (p_dcap_fixed) else $error("device caps fixed fields wrong");
   a_dcap_live:
      assert property (p_dcap_live) else $error("device caps live fields disagree");
   a_capture:
      assert property (p_capture) else $error("power limit not captured");
   a_down_zero:
      assert property (p_down_zero) else $error("downstream power fields not zero");
   a_mw:
      assert property (p_mw) else $error("milliwatt value wrong");
   a_lock:
      assert property (p_lock) else $error("locked write changed a field");
   a_wr_dcap:
      assert property (p_wr_dcap) else $error("unlocked write not taken");

   c_hdr_rd: cover property (hdr_rd);
   c_msg_up: cover property (spl_msg_valid_i && port_upstream_o);
   c_lock_wr: cover property (reg_wr_i && fields_locked_i);
endmodule

bind pcr_regs pcr_regs_properties u_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .port_upstream_i(port_upstream_i),
   .fields_locked_i(fields_locked_i), .spl_msg_valid_i(spl_msg_valid_i),
   .spl_msg_value_i(spl_msg_value_i), .spl_msg_scale_i(spl_msg_scale_i),
   .port_upstream_o(port_upstream_o), .slot_implemented_o(slot_implemented_o),
   .max_payload_supported_o(max_payload_supported_o),
   .extended_tag_supported_o(extended_tag_supported_o),
   .traffic_class_routing_o(traffic_class_routing_o),
   .captured_power_limit_value_o(captured_power_limit_value_o),
   .captured_power_limit_scale_o(captured_power_limit_scale_o),
   .slot_power_mw_o(slot_power_mw_o));
`default_nettype wire

// *** verification/tb_pcr_regs.sv ***
// Purpose: self-checking bench for the capability register bank
// Assumes: read data valid only in the cycle after the read strobe
// Notes: upstream runs first, then a second reset brings up a downstream port
`default_nettype none
module tb_pcr_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import pcr_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic strap = 1'b1;
   logic lock = 1'b0;
   logic mv = 1'b0;
   logic [7:0] mval = 8'h00;
   logic [1:0] msc = 2'h0;
   logic [31:0] rdata;
   logic [17:0] mw;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;

   always #2.5 ref_clk_i = ~ref_clk_i;

   pcr_regs u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .port_upstream_i(strap), .fields_locked_i(lock), .spl_msg_valid_i(mv),
      .spl_msg_value_i(mval), .spl_msg_scale_i(msc), .port_upstream_o(),
      .slot_implemented_o(), .max_payload_supported_o(), .extended_tag_supported_o(),
      .traffic_class_routing_o(), .captured_power_limit_value_o(),
      .captured_power_limit_scale_o(), .slot_power_mw_o(mw));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk_i);
      wr <= 1'b0;
   endtask

   // strobe sampled at the second edge; data stands just after it
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      @(posedge ref_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   task automatic send_msg(input logic [7:0] v, input logic [1:0] s);
      @(posedge ref_clk_i);
      mv <= 1'b1;
      mval <= v;
      msc <= s;
      @(posedge ref_clk_i);
      mv <= 1'b0;
   endtask

   // the extra edge after release is the one that captures the strap
   task automatic do_reset(input logic up);
      rst_i <= 1'b1;
      strap <= up;
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic t_reset_up();
      rd_chk(12'h040, 32'h4051_C010);
      rd_chk(12'h044, 32'h0000_8024);
      rd_chk(12'h048, 32'h0000_0000);
      $display("test reset values done");
   endtask

   task automatic t_lock();
      @(posedge ref_clk_i);
      lock <= 1'b1;
      wr_reg(12'h040, 32'hFEFF_FFFF);
      wr_reg(12'h044, 32'hFFFF_FFFF);
      lock <= 1'b0;
      rd_chk(12'h040, 32'h4051_C010);
      rd_chk(12'h044, 32'h0000_8024);
      $display("test locked writes done");
   endtask

   task automatic t_write();
      wr_reg(12'h040, 32'hFEFF_FFFF);
      rd_chk(12'h040, 32'h405F_FF10);
      wr_reg(12'h044, 32'hFFFF_FFFF);
      rd_chk(12'h044, 32'h0000_8027);
      wr_reg(12'h048, 32'hFFFF_FFFF);
      rd_chk(12'h048, 32'h0000_0000);
      wr_reg(12'h040, 32'h0000_0000);
      rd_chk(12'h040, 32'h0050_0010);
      wr_reg(12'h044, 32'h0000_0000);
      rd_chk(12'h044, 32'h0000_8000);
      $display("test unlocked writes done");
   endtask

   // every scale code once; the first message is overwritten by the next
   task automatic t_power();
      logic [17:0] fac [4];
      logic [7:0] v;
      logic [1:0] s;
      fac = '{PCR_MW_X1, PCR_MW_X0P1, PCR_MW_X0P01, PCR_MW_X0P001};
      send_msg(8'h01, 2'h3);
      for (int i = 0; i < 4; i++) begin
         s = i[1:0];
         v = 8'hC8 ^ {6'h00, s};
         send_msg(v, s);
         rd_chk(12'h044, {4'h0, s, v, 18'h0_8000});
         chk({14'h0000, mw}, {14'h0000, 18'(v * fac[s])});
      end
      $display("test power limit capture done");
   endtask

   task automatic t_down();
      @(posedge ref_clk_i);
      do_reset(1'b0);
      rd_chk(12'h040, 32'h4061_C010);
      send_msg(8'hFF, 2'h3);
      rd_chk(12'h044, 32'h0000_8024);
      chk({14'h0000, mw}, 32'h0000_0000);
      wr_reg(12'h040, 32'hFFFF_FFFF);
      rd_chk(12'h040, 32'h416F_FF10);
      $display("test downstream port done");
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // the whole run needs under a hundred cycles
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         $display("unexpected at %0t: run did not finish", $time);
         wrap_up();
      end
   end

   initial begin
      do_reset(1'b1);
      t_reset_up();
      t_lock();
      t_write();
      t_power();
      t_down();
      wrap_up();
   end
endmodule
`default_nettype wire
